// ==== hw/ssp_serial_port.sv ====
// Serial port channel: clock synchronous and asynchronous modes, flow control.
// Assumes pins already synchronous to i_clk_sys and a single-cycle strobe register port.
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/100ps
module ssp_serial_port (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic [ssp_pkg::ADDR_W-1:0] i_addr,
	input wire logic [ssp_pkg::DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [ssp_pkg::DATA_W-1:0] o_rdata,
	input wire logic i_rxd,
	output logic o_txd,
	input wire logic i_clk_pin,
	output logic o_clk_pin,
	output logic o_clk_pin_oe_n,
	output logic o_clk_alt,
	input wire logic i_flow,
	output logic o_flow,
	output logic o_flow_oe_n,
	input wire logic i_cts_alt,
	output logic o_tx_irq,
	output logic o_rx_irq
);
	import ssp_pkg::*;

	ssp_state_t st_r;
	ssp_state_t st_nxt;
	ssp_mode_t md;
	ssp_ctrl0_t c0;
	ssp_ctrl1_t c1;
	ssp_shared_t sh;
	logic [3:0] len;
	logic [3:0] rx_total;
	logic [CHAR_W-1:0] tx_char;
	logic tx_par;
	logic src_en;
	logic os;
	logic ext_fall;
	logic ext_rise;
	logic launch;
	logic sample;
	logic cts_sep;
	logic cts_used;
	logic cts_lvl;
	logic cts_ok;
	logic load;
	logic rxl;
	logic int_clk;
	logic clk_lvl;
	logic rd_rx;

	// Field aliases
	assign md = st_r.mode;
	assign c0 = st_r.ctrl0;
	assign c1 = st_r.ctrl1;
	assign sh = st_r.shared;

	// Frame shape; synchronous mode always moves 8 bits
	assign len = md.sync_mode ? BITS8 : char_bits(md.char_len);
	assign rx_total = len + {3'h0, md.parity_en & ~md.sync_mode} + 4'h1 + {3'h0, md.two_stop};
	assign tx_char = order_char(st_r.transmit_buffer, len, c0.bit_order_select, c1.data_logic_reverse);
	assign tx_par = (^tx_char) ^ md.parity_odd;

	// Count source: prescaled internal clock or rising edge of the clock pin
	always_comb begin
		if (md.clock_source_direction) begin
			src_en = i_clk_pin & ~st_r.clk_d;
		end else if (c0.count_source == SRC_F1) begin
			src_en = 1'b1;
		end else if (c0.count_source == SRC_F2) begin
			src_en = st_r.pre[0] == PRE2_END[0];
		end else if (c0.count_source == SRC_F8) begin
			src_en = st_r.pre[2:0] == PRE8_END[2:0];
		end else begin
			src_en = st_r.pre == PRE32_END;
		end
	end
	assign os = src_en & (st_r.bcnt == BAUD_RST);

	// Synchronous edges: falling launches, rising samples, swapped by polarity
	assign ext_fall = (st_r.clk_d ^ c0.clock_polarity_select) & ~(i_clk_pin ^ c0.clock_polarity_select);
	assign ext_rise = ~(st_r.clk_d ^ c0.clock_polarity_select) & (i_clk_pin ^ c0.clock_polarity_select);
	assign launch = md.sync_mode & (st_r.tx_st == TX_RUN)
		& (md.clock_source_direction ? ext_fall : (os & st_r.sclk));
	assign sample = md.sync_mode & (st_r.tx_st == TX_RUN)
		& (md.clock_source_direction ? ext_rise : (os & ~st_r.sclk));

	// Clear-to-send source and gating
	assign cts_sep = sh.alternate_cts_source & ~sh.clock_pin_select_high;
	assign cts_used = ~c0.flow_control_disable & (~c0.flow_control_direction_select | cts_sep);
	assign cts_lvl = cts_sep ? i_cts_alt : i_flow;
	assign cts_ok = ~cts_used | ~cts_lvl;
	assign load = (st_r.tx_st == TX_IDLE) & c1.transmit_enable & ~st_r.transmit_buffer_empty_flag & cts_ok;

	assign rxl = i_rxd ^ md.line_invert;
	assign int_clk = md.sync_mode & ~md.clock_source_direction;
	assign clk_lvl = st_r.sclk ^ c0.clock_polarity_select;
	assign rd_rx = i_rd & (i_addr == A_RXBUF);

	// Next state of the whole channel
	always_comb begin
		logic commit;
		logic [CHAR_W-1:0] raw;
		logic [3:0] sp;
		commit = 1'b0;
		raw = '0;
		sp = '0;
		st_nxt = st_r;
		st_nxt.tx_irq = 1'b0;
		st_nxt.rx_irq = 1'b0;
		st_nxt.rdata = '0;
		st_nxt.clk_d = i_clk_pin;
		st_nxt.pre = st_r.pre + 5'h01;
		// Baud divider: reload at zero gives one tick per divider plus one
		if (src_en) begin
			st_nxt.bcnt = (st_r.bcnt == BAUD_RST) ? st_r.baud_divider : st_r.bcnt - 8'h01;
		end
		// Transmitter, also the shift engine of synchronous mode
		case (st_r.tx_st)
			TX_IDLE: begin
				if (load) begin
					st_nxt.tx_st = TX_RUN;
					st_nxt.transmit_buffer_empty_flag = 1'b1;
					st_nxt.tx_irq = ~c1.transmit_interrupt_source;
					st_nxt.ttk = '0;
					if (md.sync_mode) begin
						st_nxt.tsh = FRAME_W'(tx_char);
						st_nxt.tleft = BITS8;
						st_nxt.ridx = '0;
						st_nxt.sclk = 1'b1;
					end else begin
						st_nxt.tsh = build_frame(tx_char, len, md.parity_en, tx_par) >> 1;
						st_nxt.txd = 1'b0 ^ md.line_invert;
						st_nxt.tleft = rx_total;
					end
				end else if (~md.sync_mode) begin
					st_nxt.txd = ~md.line_invert;
				end
			end
			TX_RUN: begin
				if (md.sync_mode) begin
					if (int_clk & os) begin
						st_nxt.sclk = ~st_r.sclk;
					end
					if (launch) begin
						st_nxt.txd = st_r.tsh[0];
						st_nxt.tsh = st_r.tsh >> 1;
					end
					if (sample) begin
						st_nxt.rsh[st_r.ridx] = i_rxd;
						st_nxt.ridx = st_r.ridx + 4'h1;
						st_nxt.tleft = st_r.tleft - 4'h1;
						if (st_r.tleft == 4'h1) begin
							st_nxt.tx_st = TX_IDLE;
							st_nxt.tx_irq = c1.transmit_interrupt_source;
							commit = c1.receive_enable;
						end
					end
				end else if (os) begin
					st_nxt.ttk = st_r.ttk + 4'h1;
					if (st_r.ttk == OVS_END) begin
						if (st_r.tleft == '0) begin
							st_nxt.tx_st = TX_IDLE;
							st_nxt.tx_irq = c1.transmit_interrupt_source;
						end else begin
							st_nxt.txd = st_r.tsh[0] ^ md.line_invert;
							st_nxt.tsh = st_r.tsh >> 1;
							st_nxt.tleft = st_r.tleft - 4'h1;
						end
					end
				end
			end
			default: st_nxt.tx_st = TX_IDLE;
		endcase
		// Asynchronous receiver
		case (st_r.rx_st)
			RX_IDLE: begin
				if (~md.sync_mode & c1.receive_enable & ~rxl) begin
					st_nxt.rx_st = RX_START;
					st_nxt.rtk = '0;
					st_nxt.ovr_pend = 1'b0;
				end
			end
			RX_START: begin
				if (os) begin
					st_nxt.rtk = st_r.rtk + 4'h1;
					if (st_r.rtk == HALF_END) begin
						st_nxt.rx_st = rxl ? RX_IDLE : RX_BITS;
						st_nxt.rtk = '0;
						st_nxt.ridx = '0;
					end
				end
			end
			RX_BITS: begin
				if (os) begin
					st_nxt.rtk = st_r.rtk + 4'h1;
					if (st_r.rtk == OVS_END) begin
						st_nxt.rsh[st_r.ridx] = rxl;
						st_nxt.ridx = st_r.ridx + 4'h1;
						if ((st_r.ridx == rx_total - 4'h2) & st_r.rx_full) begin
							st_nxt.ovr_pend = 1'b1;
							st_nxt.overrun_err = 1'b1;
						end
						if (st_r.ridx == rx_total - 4'h1) begin
							st_nxt.rx_st = RX_IDLE;
							commit = 1'b1;
						end
					end
				end
			end
			default: st_nxt.rx_st = RX_IDLE;
		endcase
		// Register writes; a write refills the buffer even beside a load
		if (i_wr) begin
			if (i_addr == A_TXBUF) begin
				st_nxt.transmit_buffer = i_wdata[CHAR_W-1:0];
				st_nxt.transmit_buffer_empty_flag = 1'b0;
			end else if (i_addr == A_BAUD) begin
				st_nxt.baud_divider = i_wdata[7:0];
			end else if (i_addr == A_MODE) begin
				st_nxt.mode = ssp_mode_t'(i_wdata[$bits(ssp_mode_t)-1:0]);
			end else if (i_addr == A_CTRL0) begin
				st_nxt.ctrl0 = ssp_ctrl0_t'(i_wdata[$bits(ssp_ctrl0_t)-1:0]);
			end else if (i_addr == A_CTRL1) begin
				st_nxt.ctrl1 = ssp_ctrl1_t'(i_wdata[$bits(ssp_ctrl1_t)-1:0]);
			end else if (i_addr == A_SHARED) begin
				st_nxt.shared = ssp_shared_t'(i_wdata[$bits(ssp_shared_t)-1:0]);
			end
		end
		// Register reads, data one cycle later
		if (i_rd) begin
			if (i_addr == A_RXBUF) begin
				st_nxt.rdata = ssp_rxread_t'{err_sum: st_r.overrun_err | st_r.framing_err | st_r.parity_err,
					parity_err: st_r.parity_err, framing_err: st_r.framing_err,
					overrun_err: st_r.overrun_err, pad: '0, data: st_r.receive_buffer};
			end else if (i_addr == A_BAUD) begin
				st_nxt.rdata = DATA_W'(st_r.baud_divider);
			end else if (i_addr == A_MODE) begin
				st_nxt.rdata = DATA_W'(st_r.mode);
			end else if (i_addr == A_CTRL0) begin
				st_nxt.rdata = DATA_W'({st_r.tx_st == TX_IDLE, st_r.ctrl0});
			end else if (i_addr == A_CTRL1) begin
				st_nxt.rdata = DATA_W'({st_r.rx_full, st_r.transmit_buffer_empty_flag, st_r.ctrl1});
			end else if (i_addr == A_SHARED) begin
				st_nxt.rdata = DATA_W'(st_r.shared);
			end
		end
		// Buffer read frees the buffer and clears errors; events below still win
		if (rd_rx) begin
			st_nxt.rx_full = 1'b0;
			st_nxt.overrun_err = 1'b0;
			st_nxt.framing_err = 1'b0;
			st_nxt.parity_err = 1'b0;
			if (md.sync_mode & c1.continuous_receive_enable) begin
				st_nxt.transmit_buffer_empty_flag = 1'b0;
			end
		end
		if (st_nxt.ovr_pend & (st_r.rx_st == RX_BITS)) begin
			st_nxt.overrun_err = 1'b1;
		end
		// Move a finished character into the receive buffer
		if (commit) begin
			sp = len + {3'h0, md.parity_en & ~md.sync_mode};
			raw = order_char(st_nxt.rsh[CHAR_W-1:0], len, 1'b0, 1'b0);
			st_nxt.ovr_pend = 1'b0;
			if (st_r.ovr_pend | (md.sync_mode & st_r.rx_full)) begin
				st_nxt.overrun_err = 1'b1;
			end else begin
				st_nxt.receive_buffer = order_char(raw, len, c0.bit_order_select, c1.data_logic_reverse);
				st_nxt.rx_full = 1'b1;
				st_nxt.rx_irq = 1'b1;
				if (~md.sync_mode) begin
					st_nxt.parity_err = md.parity_en & ((^raw) ^ st_nxt.rsh[len] ^ md.parity_odd);
					st_nxt.framing_err = ~st_nxt.rsh[sp] | (md.two_stop & ~st_nxt.rsh[sp + 4'h1]);
				end
			end
		end
		// Transfer clock pins: main pin unless routed to the alternate pin
		st_nxt.clk_oe_n = ~(int_clk & ~(sh.clock_pin_select_high & sh.clock_pin_select_low));
		st_nxt.clk_o = st_nxt.clk_oe_n ? ~c0.clock_polarity_select : clk_lvl;
		st_nxt.clk_alt = (int_clk & sh.clock_pin_select_high & sh.clock_pin_select_low)
			? clk_lvl : ~c0.clock_polarity_select;
		// Flow pin: port, CTS input or RTS output
		st_nxt.flow_oe_n = c0.flow_control_disable | ~c0.flow_control_direction_select;
		if (launch | ((st_r.rx_st == RX_IDLE) & (st_nxt.rx_st == RX_START))) begin
			st_nxt.flow = 1'b1;
		end else if (c1.receive_enable & ~st_r.rx_full
			& (md.sync_mode ? st_r.tx_st == TX_IDLE : st_r.rx_st == RX_IDLE)) begin
			st_nxt.flow = 1'b0;
		end
	end

	// State register
	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from the state record
	assign o_rdata = st_r.rdata;
	assign o_txd = st_r.txd;
	assign o_clk_pin = st_r.clk_o;
	assign o_clk_pin_oe_n = st_r.clk_oe_n;
	assign o_clk_alt = st_r.clk_alt;
	assign o_flow = st_r.flow;
	assign o_flow_oe_n = st_r.flow_oe_n;
	assign o_tx_irq = st_r.tx_irq;
	assign o_rx_irq = st_r.rx_irq;

	// Checks
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rstn);

	AST_RXREAD_MARKS_DATA: assert property (
		rd_rx && md.sync_mode && c1.continuous_receive_enable && !i_wr |=> !st_r.transmit_buffer_empty_flag)
		else $error("buffer read did not mark transmit data present");
	AST_START_GATED: assert property (
		st_r.tx_st == TX_IDLE ##1 st_r.tx_st == TX_RUN |-> $past(c1.transmit_enable) && $past(cts_ok))
		else $error("transfer started without enable or clear to send");
	AST_TX_IRQ_LOAD: assert property (
		load && !c1.transmit_interrupt_source |=> o_tx_irq && st_r.transmit_buffer_empty_flag | $past(i_wr))
		else $error("no transmit interrupt at buffer move");
	AST_RX_IRQ: assert property (
		o_rx_irq |-> st_r.rx_full && $past(st_r.tx_st == TX_RUN || st_r.rx_st == RX_BITS))
		else $error("receive interrupt without a finished character");
	AST_OVR_QUIET: assert property (
		st_r.ovr_pend && st_r.rx_st == RX_BITS && st_nxt.rx_st == RX_IDLE |=> !o_rx_irq && st_r.overrun_err)
		else $error("overrun raised a receive interrupt");
	AST_ERR_SUM: assert property (
		rd_rx |=> o_rdata[DATA_W-1] == ($past(st_r.overrun_err) | $past(st_r.framing_err) | $past(st_r.parity_err)))
		else $error("error summary disagrees with error flags");
	AST_RX_START: assert property (
		st_r.rx_st == RX_IDLE && st_nxt.rx_st == RX_START |-> c1.receive_enable && !rxl && !md.sync_mode)
		else $error("reception began without enable or start bit");
	AST_RTS_HIGH: assert property (
		launch |=> o_flow)
		else $error("ready to send not raised at first clock edge");
	AST_FLOW_PORT: assert property (
		c0.flow_control_disable ##1 c0.flow_control_disable |-> o_flow_oe_n)
		else $error("flow pin driven while disabled");
	AST_TXD_IDLE: assert property (
		!md.sync_mode && st_r.tx_st == TX_IDLE && $past(st_r.tx_st == TX_IDLE) && $stable(md)
		&& $past(st_r.tx_st == TX_IDLE, 2) |-> o_txd == !md.line_invert)
		else $error("idle line level ignores polarity switch");
endmodule : ssp_serial_port

// ==== hw/ssp_pkg.sv ====
// Constants, register layouts and state record of the serial port channel.
// Assumes one 50 MHz system clock and a plain strobe register port.
package ssp_pkg;
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int CHAR_W = 9;
	localparam int FRAME_W = 13;
	// Register addresses
	localparam logic [ADDR_W-1:0] A_TXBUF = 4'h0;
	localparam logic [ADDR_W-1:0] A_RXBUF = 4'h1;
	localparam logic [ADDR_W-1:0] A_BAUD = 4'h2;
	localparam logic [ADDR_W-1:0] A_MODE = 4'h3;
	localparam logic [ADDR_W-1:0] A_CTRL0 = 4'h4;
	localparam logic [ADDR_W-1:0] A_CTRL1 = 4'h5;
	localparam logic [ADDR_W-1:0] A_SHARED = 4'h6;
	// Character length codes and bit counts
	localparam logic [1:0] LEN7 = 2'h0;
	localparam logic [1:0] LEN8 = 2'h1;
	localparam logic [1:0] LEN9 = 2'h2;
	localparam logic [3:0] BITS7 = 4'h7;
	localparam logic [3:0] BITS8 = 4'h8;
	localparam logic [3:0] BITS9 = 4'h9;
	// Count source codes and prescaler terminal values
	localparam logic [1:0] SRC_F1 = 2'h0;
	localparam logic [1:0] SRC_F2 = 2'h1;
	localparam logic [1:0] SRC_F8 = 2'h2;
	localparam logic [4:0] PRE2_END = 5'h01;
	localparam logic [4:0] PRE8_END = 5'h07;
	localparam logic [4:0] PRE32_END = 5'h1f;
	// Oversampling: 16 ticks a bit, sample start bit at tick 8
	localparam logic [3:0] OVS_END = 4'hf;
	localparam logic [3:0] HALF_END = 4'h7;
	localparam logic [7:0] BAUD_RST = 8'h00;

	typedef struct packed {
		logic line_invert;
		logic parity_odd;
		logic parity_en;
		logic two_stop;
		logic clock_source_direction;
		logic [1:0] char_len;
		logic sync_mode;
	} ssp_mode_t;
	typedef struct packed {
		logic bit_order_select;
		logic clock_polarity_select;
		logic flow_control_disable;
		logic flow_control_direction_select;
		logic [1:0] count_source;
	} ssp_ctrl0_t;
	typedef struct packed {
		logic data_logic_reverse;
		logic continuous_receive_enable;
		logic transmit_interrupt_source;
		logic receive_enable;
		logic transmit_enable;
	} ssp_ctrl1_t;
	typedef struct packed {
		logic alternate_cts_source;
		logic clock_pin_select_high;
		logic clock_pin_select_low;
	} ssp_shared_t;
	typedef struct packed {
		logic err_sum;
		logic parity_err;
		logic framing_err;
		logic overrun_err;
		logic [2:0] pad;
		logic [CHAR_W-1:0] data;
	} ssp_rxread_t;
	typedef enum logic {TX_IDLE, TX_RUN} ssp_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS} ssp_rx_st_t;
	typedef struct packed {
		ssp_mode_t mode;
		ssp_ctrl0_t ctrl0;
		ssp_ctrl1_t ctrl1;
		ssp_shared_t shared;
		logic [7:0] baud_divider;
		logic [CHAR_W-1:0] transmit_buffer;
		logic transmit_buffer_empty_flag;
		logic [CHAR_W-1:0] receive_buffer;
		logic rx_full;
		logic overrun_err;
		logic framing_err;
		logic parity_err;
		logic ovr_pend;
		logic [4:0] pre;
		logic [7:0] bcnt;
		ssp_tx_st_t tx_st;
		logic [FRAME_W-1:0] tsh;
		logic [3:0] tleft;
		logic [3:0] ttk;
		logic sclk;
		logic clk_d;
		ssp_rx_st_t rx_st;
		logic [FRAME_W-1:0] rsh;
		logic [3:0] ridx;
		logic [3:0] rtk;
		logic txd;
		logic clk_o;
		logic clk_oe_n;
		logic clk_alt;
		logic flow;
		logic flow_oe_n;
		logic [DATA_W-1:0] rdata;
		logic tx_irq;
		logic rx_irq;
	} ssp_state_t;
	localparam ssp_state_t ST_RST = '{tx_st: TX_IDLE, rx_st: RX_IDLE, transmit_buffer_empty_flag: 1'b1,
		sclk: 1'b1, txd: 1'b1, clk_o: 1'b1, clk_oe_n: 1'b1, clk_alt: 1'b1, flow: 1'b1, flow_oe_n: 1'b1,
		baud_divider: BAUD_RST, default: '0};

	// Character length in bits
	function automatic logic [3:0] char_bits(input logic [1:0] code);
		if (code == LEN8) begin
			return BITS8;
		end else if (code == LEN9) begin
			return BITS9;
		end
		return BITS7;
	endfunction : char_bits

	// Reorders and optionally inverts a character; masks bits above its length
	function automatic logic [CHAR_W-1:0] order_char(input logic [CHAR_W-1:0] d, input logic [3:0] len,
		input logic msb, input logic inv);
		logic [CHAR_W-1:0] r;
		r = '0;
		for (int i = 0; i < CHAR_W; i++) begin
			if (i < int'(len)) begin
				r[i] = inv ^ (msb ? d[int'(len) - 1 - i] : d[i]);
			end
		end
		return r;
	endfunction : order_char

	// Start bit, character, optional parity, idle ones as stop bits
	function automatic logic [FRAME_W-1:0] build_frame(input logic [CHAR_W-1:0] c, input logic [3:0] len,
		input logic pen, input logic par);
		logic [FRAME_W-1:0] f;
		f = '1;
		f[0] = 1'b0;
		for (int i = 0; i < CHAR_W; i++) begin
			if (i < int'(len)) begin
				f[i + 1] = c[i];
			end
		end
		if (pen) begin
			f[int'(len) + 1] = par;
		end
		return f;
	endfunction : build_frame
endpackage : ssp_pkg

// ==== sim/ssp_far_end.sv ====
// Far-end serial device: drives the receive line and captures frames from the transmit line.
// Assumes divider 0 with the undivided source, so one bit lasts 16 system clocks; lines idle high.
`timescale 1ns/100ps
module ssp_far_end (
	input wire logic i_clk_sys,
	input wire logic i_line,
	output logic o_line
);
	int bit_cyc = 16;
	int cap_bits = 9;
	logic [12:0] got_q[$];
	initial o_line = 1'b1;
	// Sends start, character, parity and stops LSB first, then idles high
	task automatic send(input logic [13:0] f, input int n);
		for (int i = 0; i < n; i++) begin
			o_line <= f[i];
			repeat (bit_cyc) @(posedge i_clk_sys);
		end
		o_line <= 1'b1;
	endtask : send
	// Samples every bit after the start bit at mid-bit
	always begin : cap_blk
		logic [12:0] v;
		@(negedge i_line);
		v = '1;
		repeat (bit_cyc / 2) @(posedge i_clk_sys);
		for (int i = 0; i < cap_bits; i++) begin
			repeat (bit_cyc) @(posedge i_clk_sys);
			v[i] = i_line;
		end
		got_q.push_back(v);
	end
endmodule : ssp_far_end

// ==== sim/ssp_serial_port_bench.sv ====
// Bench of the serial port channel: register tasks, far-end model, asynchronous frame scenarios.
// Assumes divider 0 and the undivided count source, matching the far-end bit time.
`timescale 1ns/100ps
module ssp_serial_port_bench;
	import ssp_pkg::*;
	logic i_clk_sys = 1'b0;
	logic i_rstn = 1'b0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_flow = 1'b1;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wdata = '0;
	logic [DATA_W-1:0] o_rdata;
	logic o_txd, rxd, o_tx_irq, o_rx_irq;
	int err_count = 0;
	int total_checks = 0;
	int tx_irqs = 0;
	int rx_irqs = 0;

	ssp_serial_port ssp_serial_port_inst (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rxd(rxd), .o_txd(o_txd),
		.i_clk_pin(1'b0), .o_clk_pin(), .o_clk_pin_oe_n(), .o_clk_alt(), .i_flow(i_flow), .o_flow(),
		.o_flow_oe_n(), .i_cts_alt(1'b1), .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq));
	ssp_far_end ssp_far_end_inst (.i_clk_sys(i_clk_sys), .i_line(o_txd), .o_line(rxd));

	// Clock and interrupt pulse counters
	always #10 i_clk_sys = ~i_clk_sys;
	always @(posedge i_clk_sys) if (o_tx_irq === 1'b1) tx_irqs++;
	always @(posedge i_clk_sys) if (o_rx_irq === 1'b1) rx_irqs++;

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_wr <= 1'b0;
		@(posedge i_clk_sys);
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_rd <= 1'b0;
		#1 d = o_rdata;
		@(posedge i_clk_sys);
	endtask : rd
	// Line frame after the start bit: character, parity, idle-high stops
	function automatic logic [12:0] frm(input int d, input int len, input int pen, input int podd);
		logic [12:0] f = '1;
		for (int i = 0; i < len; i++) f[i] = d[i];
		if (pen != 0) f[len] = 1'(($countones(d & ((1 << len) - 1)) + podd) % 2);
		return f;
	endfunction : frm
	// Bit order and data reversal of a character
	function automatic int xf(input int v, input int len, input int msb, input int inv);
		int r = 0;
		for (int i = 0; i < len; i++) r[i] = inv[0] ^ (msb != 0 ? v[len - 1 - i] : v[i]);
		return r;
	endfunction : xf
	task automatic txq(input logic [12:0] e);
		int n = 0;
		while (ssp_far_end_inst.got_q.size() == 0 && n < 400) begin
			@(posedge i_clk_sys);
			n++;
		end
		check(16'(n < 400), 16'h1);
		check(16'(ssp_far_end_inst.got_q.pop_front()), 16'(e));
	endtask : txq
	task automatic wait_rx();
		int n = 0;
		do begin
			@(posedge i_clk_sys);
			#1 n++;
		end while (o_rx_irq !== 1'b1 && n < 400);
		check(16'(n < 400), 16'h1);
		@(posedge i_clk_sys);
	endtask : wait_rx
	task automatic rxq(input logic [12:0] f, input int n);
		fork
			ssp_far_end_inst.send({f, 1'b0}, n + 1);
			wait_rx();
		join
	endtask : rxq
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	// Watchdog against a hung handshake
	initial begin
		#400000;
		err_count++;
		print_verdict();
	end

	// Main sequence
	initial begin : main
		int d, n;
		logic [12:0] f;
		logic [15:0] v;
		void'($urandom(81632));
		repeat (20) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		@(posedge i_clk_sys);
		rd(A_CTRL1, v);
		check(v, 16'h0020);
		rd(4'h9, v);
		check(v, 16'h0000);
		// 8N1; CTS held high blocks the start
		wr(A_MODE, 16'h0002);
		wr(A_CTRL1, 16'h0003);
		wr(A_TXBUF, 16'h00a5);
		repeat (40) @(posedge i_clk_sys);
		check(16'(ssp_far_end_inst.got_q.size()), 16'h0);
		i_flow <= 1'b0;
		txq(frm(8'ha5, 8, 0, 0));
		// Bit order and data reversal in both directions
		for (int c = 0; c < 4; c++) begin
			wr(A_CTRL0, {10'h0, c[0], 5'h0});
			wr(A_CTRL1, {11'h0, c[1], 4'h3});
			d = $urandom % 256;
			wr(A_TXBUF, 16'(d));
			txq(frm(xf(d, 8, c & 1, c >> 1), 8, 0, 0));
			d = $urandom % 256;
			rxq(frm(d, 8, 0, 0), 9);
			rd(A_RXBUF, v);
			check(v, 16'(xf(d, 8, c & 1, c >> 1)));
		end
		// 9 bits, odd parity, two stops; both interrupt timings
		wr(A_CTRL0, 16'h0000);
		wr(A_MODE, 16'h0074);
		ssp_far_end_inst.cap_bits = 12;
		for (int s = 0; s < 2; s++) begin
			wr(A_CTRL1, 16'(3 + 4 * s));
			n = tx_irqs;
			d = $urandom % 512;
			wr(A_TXBUF, 16'(d));
			txq(frm(d, 9, 1, 1));
			check(16'(tx_irqs - n), 16'(1 - s));
			repeat (40) @(posedge i_clk_sys);
			check(16'(tx_irqs - n), 16'h1);
		end
		// 7 bits even parity: good, bad parity, missing stop
		wr(A_MODE, 16'h0020);
		for (int k = 0; k < 3; k++) begin
			d = $urandom % 128;
			f = frm(d, 7, 1, 0);
			if (k == 1) f[7] = ~f[7];
			if (k == 2) f[8] = 1'b0;
			rxq(f, 9);
			rd(A_RXBUF, v);
			check(v, {k != 0, k == 1, k == 2, 4'h0, 9'(d)});
		end
		// Second character while the first is unread
		rxq(frm(8'h15, 7, 1, 0), 9);
		n = rx_irqs;
		ssp_far_end_inst.send({frm(8'h6a, 7, 1, 0), 1'b0}, 10);
		repeat (20) @(posedge i_clk_sys);
		check(16'(rx_irqs - n), 16'h0);
		rd(A_RXBUF, v);
		check({12'h0, v[15:12]}, 16'h0009);
		// Continuous receive: buffer read marks transmit data present
		wr(A_MODE, 16'h0001);
		wr(A_CTRL1, 16'h0008);
		rd(A_RXBUF, v);
		rd(A_CTRL1, v);
		check(v, 16'h0008);
		print_verdict();
	end
endmodule : ssp_serial_port_bench
